// [hw/gpio_pkg.sv]
// types shared by the gpio block
package gpio_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [5:0] reg_index_t;
    typedef logic [3:0] nibble_t;
endpackage

// [hw/gpio_ports.sv]
// three-port gpio block: small port, input port, third port
`timescale 1ns/1ps
`include "gpio_regs.svh"
module gpio_ports import gpio_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [3:0] small_pin_i,
    output logic [3:0] small_pin_o,
    output logic [3:0] small_pin_oe_o,
    output logic [3:0] small_pullup_o,
    output logic led_boost_o,
    input wire logic [7:0] input_pin_i,
    output logic [7:0] input_pullup_o,
    input wire logic ext_irq_one_en_i,
    input wire logic ext_irq_zero_en_i,
    input wire logic timer_count_sel_i,
    input wire logic comparator_en_i,
    output logic [7:0] input_sync_o,
    output logic [3:0] small_sync_o,
    output logic [7:0] third_sync_o,
    output logic low_level_o,
    input wire logic [7:0] third_pin_i,
    output logic [7:0] third_pin_o,
    output logic [7:0] third_pin_oe_o,
    output logic [7:0] third_pullup_o
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    nibble_t small_port_output_latch;
    nibble_t small_port_control;
    byte_t third_port_direction;
    byte_t third_port_output_latch;
    logic input_port_pullup_enable;

    // ----------------------------------------------------------------
    // pin-side flops
    // ----------------------------------------------------------------
    nibble_t small_out_q;
    nibble_t small_oe_q;
    nibble_t small_pull_q;
    byte_t input_pull_q;
    byte_t third_oe_q;
    byte_t third_pull_q;
    logic low_q;

    // ----------------------------------------------------------------
    // synchronised pin levels
    // ----------------------------------------------------------------
    nibble_t small_sync;
    byte_t input_sync;
    byte_t third_sync;
    byte_t alt_active;
    byte_t next_input_pull;
    nibble_t small_dir;
    nibble_t next_small_pull;

    reg_access_if ra ();

    wb_reg_slave u_bus (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cyc_i(wb_cyc_i),
        .stb_i(wb_stb_i),
        .we_i(wb_we_i),
        .adr_i(wb_adr_i),
        .sel_i(wb_sel_i),
        .dat_i(wb_dat_i),
        .dat_o(wb_dat_o),
        .ack_o(wb_ack_o),
        .ra(ra)
    );

    pin_sync #(.W(4)) u_small_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(small_pin_i),
        .q_o(small_sync)
    );

    pin_sync #(.W(8)) u_input_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(input_pin_i),
        .q_o(input_sync)
    );

    pin_sync #(.W(8)) u_third_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(third_pin_i),
        .q_o(third_sync)
    );

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            small_port_output_latch <= `RST_SMALL_LATCH;
        end else if (ra.wr && ra.idx == `IDX_SMALL_LATCH) begin
            small_port_output_latch <= ra.wdata[3:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            small_port_control <= `RST_SMALL_CONTROL;
        end else if (ra.wr && ra.idx == `IDX_SMALL_CONTROL) begin
            // upper bits are not stored
            small_port_control <= ra.wdata[3:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            third_port_direction <= `RST_THIRD;
        end else if (ra.wr && ra.idx == `IDX_THIRD_DIRECTION) begin
            third_port_direction <= ra.wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            third_port_output_latch <= `RST_THIRD;
        end else if (ra.wr && ra.idx == `IDX_THIRD_LATCH) begin
            third_port_output_latch <= ra.wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            input_port_pullup_enable <= `RST_INPUT_PULLUP;
        end else if (ra.wr && ra.idx == `IDX_INPUT_CONTROL) begin
            input_port_pullup_enable <= ra.wdata[`INPUT_PULLUP_BIT];
        end
    end

    // ----------------------------------------------------------------
    // register reads; pin-read addresses have no write path
    // ----------------------------------------------------------------
    always_comb begin
        if (ra.idx == `IDX_SMALL_PIN_LEVELS) begin
            // led pin level is synchronised but reads zero
            ra.rdata = {4'h0, small_sync[3], 1'b0, small_sync[1:0]};
        end else if (ra.idx == `IDX_SMALL_LATCH) begin
            ra.rdata = {4'h0, small_port_output_latch};
        end else if (ra.idx == `IDX_SMALL_CONTROL) begin
            ra.rdata = {4'h0, small_port_control};
        end else if (ra.idx == `IDX_INPUT_PIN_LEVELS) begin
            ra.rdata = input_sync;
        end else if (ra.idx == `IDX_THIRD_PIN_LEVELS) begin
            ra.rdata = third_sync;
        end else if (ra.idx == `IDX_THIRD_DIRECTION) begin
            ra.rdata = third_port_direction;
        end else if (ra.idx == `IDX_THIRD_LATCH) begin
            ra.rdata = third_port_output_latch;
        end else if (ra.idx == `IDX_INPUT_CONTROL) begin
            ra.rdata = {7'h00, input_port_pullup_enable};
        end else begin
            ra.rdata = 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // small port drive, one stage behind the latch
    // ----------------------------------------------------------------
    always_comb begin
        small_dir = small_port_control;
        // the led pin has no direction bit, it always drives
        small_dir[`SMALL_LED_BIT] = 1'b1;
        next_small_pull = ~small_dir & small_port_output_latch;
    end

    // extra stage gives the small port its documented one-cycle lag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            small_out_q <= `RST_SMALL_LATCH;
            // led pin drives from the first cycle after reset
            small_oe_q <= `RST_SMALL_OE;
            small_pull_q <= 4'h0;
            led_boost_o <= 1'b0;
        end else begin
            small_out_q <= small_port_output_latch;
            small_oe_q <= small_dir;
            small_pull_q <= next_small_pull;
            led_boost_o <= small_port_control[`SMALL_BOOST_BIT];
        end
    end

    assign small_pin_o = small_out_q;
    // enables are gated by reset directly so pins float without a clock
    assign small_pin_oe_o = small_oe_q & {4{~rst_i}};
    assign small_pullup_o = small_pull_q & {4{~rst_i}};

    // ----------------------------------------------------------------
    // input port pull-ups and low-level detector
    // ----------------------------------------------------------------
    always_comb begin
        alt_active = {3'b000, ext_irq_one_en_i, ext_irq_zero_en_i,
                      timer_count_sel_i,
                      comparator_en_i, comparator_en_i};
        next_input_pull = {8{input_port_pullup_enable}} & ~alt_active;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            input_pull_q <= 8'h00;
        end else begin
            input_pull_q <= next_input_pull;
        end
    end

    assign input_pullup_o = input_pull_q & {8{~rst_i}};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_q <= 1'b0;
        end else begin
            // a pin taken by an alternate function never flags low
            low_q <= |(~input_sync & ~alt_active);
        end
    end

    assign low_level_o = low_q;

    // ----------------------------------------------------------------
    // third port drive
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            third_oe_q <= 8'h00;
            third_pull_q <= 8'h00;
        end else begin
            third_oe_q <= third_port_direction;
            third_pull_q <= ~third_port_direction & third_port_output_latch;
        end
    end

    assign third_pin_o = third_port_output_latch;
    assign third_pin_oe_o = third_oe_q & {8{~rst_i}};
    assign third_pullup_o = third_pull_q & {8{~rst_i}};

    // ----------------------------------------------------------------
    // synchronised levels for internal consumers
    // ----------------------------------------------------------------
    assign input_sync_o = input_sync;
    assign small_sync_o = {small_sync[3], 1'b0, small_sync[1:0]};
    assign third_sync_o = third_sync;
endmodule

// [hw/gpio_regs.svh]
// register indices, field positions, reset values of the gpio block
//
// Notes on behaviour
// - small port pins 3,1,0 output when direction bit is one, else input
// - small port input: latch 1 enables pull-up; output drives latch push-pull
// - control bit 2 enables the extra sink driver on the led pin
// - control bits 7..4 are read-only and always read zero
// - reset tri-states every pin at once, clock not needed; led_boost_o clears only on a clock edge in reset
// - small pin-read address returns pin levels, data address returns latch
// - led pin is always an output, has no direction, its pin bit reads zero
// - every pin passes synchronising flops before reads or internal use
// - input port: eight input-only pins, read-only pin-read address
// - one control bit switches all eight input port pull-ups
// - an enabled alternate function forces that pin's pull-up off
// - all input pins feed the low-level detector unless overridden
// - ext irq one or zero enabled: pin 4 or 3 loses pull-up and detection
// - timer counting on pin 2: pin 2 loses pull-up and detection
// - comparator enabled: pins 1 and 0 lose pull-up and detection
// - third port 8 bits bidirectional, data and direction reset zero
// - third port pin output when its direction bit is one, else input
// - third port input: data 1 pull-up, 0 floats; output drives push-pull
// - third port data address reads latch, pin-read address reads pins
// - small port output reaches pins one cycle later than other ports
// - small port data low four bits rw, led bit resets one, others zero
`ifndef GPIO_REGS_SVH
`define GPIO_REGS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_THIRD_PIN_LEVELS 6'h10
`define IDX_THIRD_DIRECTION 6'h11
`define IDX_THIRD_LATCH 6'h12
`define IDX_INPUT_PIN_LEVELS 6'h16
`define IDX_SMALL_PIN_LEVELS 6'h19
`define IDX_SMALL_CONTROL 6'h1a
`define IDX_SMALL_LATCH 6'h1b
`define IDX_INPUT_CONTROL 6'h30

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SMALL_DIR0_BIT 0
`define SMALL_DIR1_BIT 1
`define SMALL_BOOST_BIT 2
`define SMALL_DIR3_BIT 3
`define SMALL_LED_BIT 2
`define INPUT_PULLUP_BIT 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_SMALL_LATCH 4'h4
`define RST_SMALL_OE 4'h4
`define RST_SMALL_CONTROL 4'h0
`define RST_THIRD 8'h00
`define RST_INPUT_PULLUP 1'b0

`endif

// [hw/pin_sync.sv]
// two-stage synchroniser for a group of pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule

// [hw/reg_access_if.sv]
// register access carrier between bus slave and port core
`timescale 1ns/1ps
interface reg_access_if;
    import gpio_pkg::*;
    logic wr;
    reg_index_t idx;
    byte_t wdata;
    byte_t rdata;
    modport bus (output wr, output idx, output wdata, input rdata);
    modport core (input wr, input idx, input wdata, output rdata);
endinterface

// [hw/wb_reg_slave.sv]
// classic wishbone slave turning bus cycles into register accesses
`timescale 1ns/1ps
module wb_reg_slave import gpio_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    reg_access_if.bus ra
);
    logic req;

    assign req = cyc_i & stb_i;
    assign ra.idx = adr_i[7:2];
    assign ra.wdata = dat_i[7:0];
    // write lands on the edge where the master samples ack
    assign ra.wr = req & we_i & ack_o & sel_i[0];

    // ----------------------------------------------------------------
    // one-cycle answer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req & ~ack_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req & ~ack_o & ~we_i) begin
            dat_o <= {24'h00_0000, ra.rdata};
        end
    end
endmodule

// [tb/gpio_props.sv]
// concurrent checks on the gpio block ports
`timescale 1ns/1ps
module gpio_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [3:0] small_pin_o,
    input wire logic [3:0] small_pin_oe_o,
    input wire logic [3:0] small_pullup_o,
    input wire logic led_boost_o,
    input wire logic [7:0] input_pin_i,
    input wire logic [7:0] input_pullup_o,
    input wire logic ext_irq_one_en_i,
    input wire logic ext_irq_zero_en_i,
    input wire logic timer_count_sel_i,
    input wire logic comparator_en_i,
    input wire logic [7:0] input_sync_o,
    input wire logic low_level_o,
    input wire logic [7:0] third_pin_i,
    input wire logic [7:0] third_pin_o,
    input wire logic [7:0] third_pin_oe_o,
    input wire logic [7:0] third_pullup_o,
    input wire logic [7:0] third_sync_o
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    logic [7:0] ov;
    logic wr_ack;
    assign ov = {3'h0, ext_irq_one_en_i, ext_irq_zero_en_i,
                 timer_count_sel_i, comparator_en_i, comparator_en_i};
    assign wr_ack = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // reset check must not be masked by reset itself
    property p_rst_tri;
        @(posedge clk_i) disable iff (1'b0) rst_i |-> !(|{small_pin_oe_o,
            small_pullup_o, input_pullup_o, third_pin_oe_o, third_pullup_o});
    endproperty
    a_rst_tri: assert property (p_rst_tri)
        else $error("pins driven during reset");
    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus answer not a single cycle later");
    property p_third_out;
        wr_ack && wb_adr_i == 8'h48 |=> third_pin_o == $past(wb_dat_i[7:0]);
    endproperty
    a_third_out: assert property (p_third_out)
        else $error("third port drive late or wrong");
    property p_small_out;
        wr_ack && wb_adr_i == 8'h6c |-> ##2
            small_pin_o == $past(wb_dat_i[3:0], 2);
    endproperty
    a_small_out: assert property (p_small_out)
        else $error("small port drive timing wrong");
    property p_small_ctl;
        wr_ack && wb_adr_i == 8'h68 |-> ##2 {small_pin_oe_o, led_boost_o} ==
            {$past(wb_dat_i[3], 2), 1'b1, $past(wb_dat_i[1:0], 2),
             $past(wb_dat_i[2], 2)};
    endproperty
    a_small_ctl: assert property (p_small_ctl)
        else $error("small control not applied");
    property p_excl;
        (small_pin_oe_o & small_pullup_o) == 4'h0 && !small_pullup_o[2]
            && (third_pin_oe_o & third_pullup_o) == 8'h00;
    endproperty
    a_excl: assert property (p_excl)
        else $error("pull-up on a driving pin");
    property p_override;
        (input_pullup_o & $past(ov)) == 8'h00;
    endproperty
    a_override: assert property (p_override)
        else $error("pull-up kept on alternate pin");
    property p_pull_shared;
        wr_ack && wb_adr_i == 8'hc0 |-> ##2
            input_pullup_o[7:5] == {3{$past(wb_dat_i[0], 2)}};
    endproperty
    a_pull_shared: assert property (p_pull_shared)
        else $error("shared pull-up not applied");
    property p_low_hi;
        (&input_pin_i) [*4] |-> !low_level_o;
    endproperty
    a_low_hi: assert property (p_low_hi)
        else $error("low level seen with pins high");
    property p_low_lo;
        (input_pin_i[7:5] == 3'h0) [*4] |-> low_level_o;
    endproperty
    a_low_lo: assert property (p_low_lo)
        else $error("low level missed");
    property p_rd_zero;
        wb_ack_o && !wb_we_i && wb_adr_i inside {8'h64, 8'h68} |->
            wb_dat_o[31:4] == 28'h000_0000
            && !(wb_adr_i == 8'h64 && wb_dat_o[2]);
    endproperty
    a_rd_zero: assert property (p_rd_zero)
        else $error("reserved read bits not zero");
    // sync flops may hold reset values for two edges after release
    property p_sync;
        !$past(rst_i) && !$past(rst_i, 2) |-> {input_sync_o, third_sync_o}
            == $past({input_pin_i, third_pin_i}, 2);
    endproperty
    a_sync: assert property (p_sync)
        else $error("synchroniser depth wrong");
endmodule

bind gpio_ports gpio_props chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .small_pin_o, .small_pin_oe_o, .small_pullup_o, .led_boost_o,
    .input_pin_i, .input_pullup_o, .ext_irq_one_en_i, .ext_irq_zero_en_i,
    .timer_count_sel_i, .comparator_en_i, .input_sync_o, .low_level_o,
    .third_pin_i, .third_pin_o, .third_pin_oe_o, .third_pullup_o,
    .third_sync_o);

// [tb/pin_env.sv]
// external circuit on a group of port pins
`timescale 1ns/1ps
module pin_env (
    input wire logic clk_i,
    input wire logic [7:0] out_i,
    input wire logic [7:0] oe_i,
    input wire logic [7:0] pull_i,
    input wire logic [7:0] drv_i,
    input wire logic [7:0] drv_en_i,
    output logic [7:0] pin_o
);
    // a floating pin toggles so that no stale level can pass for a read
    logic [7:0] flt = 8'h55;
    always @(posedge clk_i) begin
        flt <= ~flt;
    end
    assign pin_o = (oe_i & out_i) | (~oe_i & drv_en_i & drv_i)
        | (~oe_i & ~drv_en_i & (pull_i | flt));
endmodule

// [tb/tb.sv]
// self-checking bench for the gpio block
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb import gpio_pkg::*; ;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, led_boost_o;
    logic ext_irq_one_en_i, ext_irq_zero_en_i, timer_count_sel_i;
    logic comparator_en_i, low_level_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i, small_pin_i, small_pin_o, small_pin_oe_o;
    logic [3:0] small_pullup_o, small_sync_o;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [7:0] input_pin_i, input_pullup_o, input_sync_o, third_sync_o;
    logic [7:0] third_pin_i, third_pin_o, third_pin_oe_o, third_pullup_o;
    logic [7:0] third_drv, third_en, small_drv, small_en, in_drv, in_en, sp;
    int errors, total_checks, seed;
    byte_t d, l, e, x, q;

    gpio_ports DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .small_pin_i,
        .small_pin_o, .small_pin_oe_o, .small_pullup_o, .led_boost_o,
        .input_pin_i, .input_pullup_o, .ext_irq_one_en_i, .ext_irq_zero_en_i,
        .timer_count_sel_i, .comparator_en_i, .input_sync_o, .small_sync_o,
        .third_sync_o, .low_level_o, .third_pin_i, .third_pin_o,
        .third_pin_oe_o, .third_pullup_o);
    pin_env pe_third (.clk_i, .out_i(third_pin_o), .oe_i(third_pin_oe_o),
        .pull_i(third_pullup_o), .drv_i(third_drv), .drv_en_i(third_en),
        .pin_o(third_pin_i));
    pin_env pe_small (.clk_i, .out_i({4'h0, small_pin_o}),
        .oe_i({4'h0, small_pin_oe_o}), .pull_i({4'h0, small_pullup_o}),
        .drv_i(small_drv), .drv_en_i(small_en), .pin_o(sp));
    pin_env pe_in (.clk_i, .out_i(8'h00), .oe_i(8'h00),
        .pull_i(input_pullup_o), .drv_i(in_drv), .drv_en_i(in_en),
        .pin_o(input_pin_i));
    assign small_pin_i = sp[3:0];

    // inputs with latch 0 are driven from outside, latch 1 pulled up
    function automatic byte_t pins(byte_t dir, byte_t lat, byte_t ext);
        return (dir & lat) | (~dir & (lat | ext));
    endfunction

    // ----------------------------------------
    // bus and closing tasks
    // ----------------------------------------
    task automatic xfer(input logic [7:0] a, input logic w, input byte_t wd,
                        output byte_t rd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h00_0000, wd};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o[7:0];
        `CHK(n, 2)
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input byte_t wd);
        byte_t t;
        xfer(a, 1'b1, wd, t);
    endtask
    task automatic rd(input logic [7:0] a, input byte_t ex);
        byte_t t;
        xfer(a, 1'b0, 8'h00, t);
        `CHK(t, ex)
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        stop_test;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        seed = 48639;
        errors = 0;
        total_checks = 0;
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} = 12'h800;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0000_0000;
        {ext_irq_one_en_i, ext_irq_zero_en_i} = 2'h0;
        {timer_count_sel_i, comparator_en_i} = 2'h0;
        {third_drv, third_en, small_drv, small_en, in_drv, in_en} = '0;
        repeat (16) @(posedge clk_i);
        `CHK({small_pin_oe_o, third_pin_oe_o}, 12'h000)
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK({small_pin_o, small_pin_oe_o}, 8'h44)
        rd(8'h44, 8'h00);
        rd(8'h48, 8'h00);
        rd(8'h68, 8'h00);
        rd(8'h6c, 8'h04);
        rd(8'hfc, 8'h00);
        for (int i = 0; i < 12; i++) begin
            d = byte_t'($random(seed));
            l = byte_t'($random(seed));
            e = byte_t'($random(seed));
            if (i < 2) {d, l} = i ? 16'hff00 : 16'h00ff;
            x = {4'h0, d[3], 1'b1, d[1:0]};
            third_drv <= e;
            third_en <= ~d & ~l;
            small_drv <= e;
            small_en <= ~x & ~l;
            wr(8'h44, d);
            wr(8'h48, l);
            wr(8'h40, ~l);
            wr(8'h68, d);
            wr(8'h6c, l);
            wr(8'h64, d);
            repeat (4) @(posedge clk_i);
            q = pins(x, l, e) & 8'h0b;
            `CHK(third_pin_oe_o, d)
            `CHK(third_pullup_o, ~d & l)
            `CHK(third_pin_o, l)
            `CHK(third_sync_o, pins(d, l, e))
            `CHK(small_pin_oe_o, x[3:0])
            `CHK(small_pullup_o, ~x[3:0] & l[3:0])
            `CHK(small_pin_o, l[3:0])
            `CHK(led_boost_o, d[2])
            `CHK(small_sync_o, q[3:0])
            rd(8'h48, l);
            rd(8'h40, pins(d, l, e));
            rd(8'h68, {4'h0, d[3:0]});
            rd(8'h6c, {4'h0, l[3:0]});
            rd(8'h64, q);
        end
        for (int i = 0; i < 34; i++) begin
            e = (i < 32) ? byte_t'($random(seed)) : (i == 32 ? 8'hff : 8'h00);
            {ext_irq_one_en_i, ext_irq_zero_en_i} <= i[3:2];
            {timer_count_sel_i, comparator_en_i} <= i[1:0];
            x = {3'h0, i[3], i[2], i[1], i[0], i[0]};
            l = (i < 32 && i[4]) ? ~x : 8'h00;
            in_drv <= e;
            in_en <= ~l;
            wr(8'hc0, {7'h00, i < 32 && i[4]});
            repeat (6) @(posedge clk_i);
            q = (e & ~l) | l;
            `CHK(input_pullup_o, l)
            `CHK(input_sync_o, q)
            `CHK(low_level_o, |(~q & ~x))
            rd(8'h58, q);
        end
        // leave drivers and pull-ups on so the reset check sees them drop
        wr(8'h44, 8'hf0);
        wr(8'h48, 8'h5a);
        wr(8'h6c, 8'h0f);
        wr(8'hc0, 8'h01);
        wr(8'h68, 8'h08);
        repeat (2) @(posedge clk_i);
        `CHK(third_pullup_o, 8'h0a)
        `CHK({small_pullup_o, input_pullup_o}, 12'h3fc)
        rst_i <= 1'b1;
        #1;
        `CHK({small_pin_oe_o, small_pullup_o, input_pullup_o}, 16'h0000)
        `CHK({third_pin_oe_o, third_pullup_o}, 16'h0000)
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK(small_pin_oe_o, 4'h4)
        rd(8'h48, 8'h00);
        rd(8'h44, 8'h00);
        rd(8'h6c, 8'h04);
        rd(8'hc0, 8'h00);
        stop_test;
    end
endmodule
